/* File: hw/ssw_pkg.sv */
// constants for the serial word store of the synthesiser control path
package ssw_pkg;
  // shift register and frame layout
  localparam int SR_W = 24;
  localparam int SEL_HI_POS = 1;
  localparam int SEL_LO_POS = 0;
  localparam int WORD_LSB = 2;
  // frequency word, 22 bits taken from sr[23:2]
  localparam int FREQ_W = 22;
  localparam int SENSE_POS = 21;
  localparam int GAIN_HI_POS = 20;
  localparam int GAIN_LO_POS = 19;
  localparam int CNT_W = 19;
  localparam int A_W = 4;
  localparam int M_W = 15;
  localparam int A_LSB = 0;
  localparam int M_LSB = 4;
  // reference word, 16 bits taken from sr[17:2]
  localparam int REF_W = 16;
  localparam int MOD_POS = 15;
  localparam int PE_HI_POS = 14;
  localparam int PE_LO_POS = 13;
  localparam int RATIO_W = 13;
  // a-count transfer takes sr[5:2]
  localparam int A_HOLD_LSB = 2;
  // buffer select codes, written {sel_hi, sel_lo}
  localparam logic [1:0] SEL_FREQ_ONE = 2'h0;
  localparam logic [1:0] SEL_FREQ_TWO = 2'h2;
  localparam logic [1:0] SEL_A_HOLD = 2'h1;
  localparam logic [1:0] SEL_REF = 2'h3;
  // pump enable codes, written {pump_enable_hi, pump_enable_lo}
  localparam logic [1:0] PE_OUTS_OFF_PUMPS_ON = 2'h0;
  localparam logic [1:0] PE_OUTS_ON_PUMP1_OFF = 2'h2;
  localparam logic [1:0] PE_OUTS_OFF_GATED = 2'h1;
  localparam logic [1:0] PE_OUTS_ON_GATED = 2'h3;
  // charge pump 1 current in microamps, per {gain_hi, gain_lo}
  localparam logic [7:0] CP1_UA_00 = 8'h32;
  localparam logic [7:0] CP1_UA_10 = 8'h4B;
  localparam logic [7:0] CP1_UA_01 = 8'h7D;
  localparam logic [7:0] CP1_UA_11 = 8'hC8;
  // charge pump 2 multiplier in half steps (x1, x1.5, x2.5, x4)
  localparam logic [3:0] CP2_HALF_00 = 4'h2;
  localparam logic [3:0] CP2_HALF_10 = 4'h3;
  localparam logic [3:0] CP2_HALF_01 = 4'h5;
  localparam logic [3:0] CP2_HALF_11 = 4'h8;
  // reset values
  localparam logic [SR_W-1:0] SR_RST = 24'h000000;
  localparam logic [FREQ_W-1:0] FREQ_RST = 22'h000000;
  localparam logic [REF_W-1:0] REF_RST = 16'h0000;
  localparam logic [A_W-1:0] A_HOLD_RST = 4'h0;
  // active buffer tracking
  typedef enum logic {SSW_ACT_ONE, SSW_ACT_TWO} ssw_act_e;
endpackage

/* File: hw/ssw_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
module ssw_sync2
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // meta_q feeds nothing but sync_out
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* File: hw/ssw_word_store.sv */
// serial front end, word buffers and pump control decode of the synthesiser
`timescale 1ns/100ps
// Notes on behaviour
// - pump one current follows active gain bits
// - pump two multiplier follows active gain bits
// - lock window drives indicator low, gates pump
// - sense bit flips pump polarity, swaps ports
// - serial data shifts into 24-bit register
// - enable falling edge copies word to buffer
// - select code picks one of four targets
// - frequency buffers hold 22 bits each
// - reference buffer holds 16 bits
// - select input high picks buffer one
// - shifting never disturbs loaded control buffers
// - store stays live during power down
// - pump enable code sets outputs, pump one
// - select toggle applies at comparison rate
// - counters reload active word each cycle
// - reference ratio spans 1 to 8191
module ssw_word_store
  import ssw_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_enable_in,
  input wire logic buffer_select_input_in,
  input wire logic lock_window_in,
  input wire logic m_cycle_end_in,
  output logic [ssw_pkg::M_W-1:0] m_ratio_out,
  output logic [ssw_pkg::A_W-1:0] a_ratio_out,
  output logic [ssw_pkg::A_W-1:0] a_count_hold_out,
  output logic [ssw_pkg::RATIO_W-1:0] ref_ratio_out,
  output logic prescaler_low_pair_out,
  output logic [7:0] cp1_current_ua_out,
  output logic [3:0] cp2_scale_half_out,
  output logic pump_sink_out,
  output logic port_swap_out,
  output logic cp1_enable_out,
  output logic cp2_enable_out,
  output logic ref_outputs_enable_out,
  output logic lock_detect_n_out,
  output logic active_is_one_out
);
  import ssw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic logic [7:0] cp1_ua(input logic [1:0] gain);
    case (gain)
      2'h0: cp1_ua = CP1_UA_00;
      2'h2: cp1_ua = CP1_UA_10;
      2'h1: cp1_ua = CP1_UA_01;
      default: cp1_ua = CP1_UA_11;
    endcase
  endfunction

  function automatic logic [3:0] cp2_half(input logic [1:0] gain);
    case (gain)
      2'h0: cp2_half = CP2_HALF_00;
      2'h2: cp2_half = CP2_HALF_10;
      2'h1: cp2_half = CP2_HALF_01;
      default: cp2_half = CP2_HALF_11;
    endcase
  endfunction

  function automatic logic pump1_on(input logic [1:0] pe, input logic in_lock);
    case (pe)
      PE_OUTS_OFF_PUMPS_ON: pump1_on = 1'b1;
      PE_OUTS_ON_PUMP1_OFF: pump1_on = 1'b0;
      default: pump1_on = ~in_lock;
    endcase
  endfunction

  function automatic logic refs_on(input logic [1:0] pe);
    case (pe)
      PE_OUTS_ON_PUMP1_OFF: refs_on = 1'b1;
      PE_OUTS_ON_GATED: refs_on = 1'b1;
      default: refs_on = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shift register on the serial clock

  logic [SR_W-1:0] sr_q;
  logic [SR_W-1:0] sr_d;

  // new bit enters at the bottom, so the select bits land in sr[1:0]
  assign sr_d = {sr_q[SR_W-2:0], ser_data_in};

  // the serial clock may stop between frames; nothing here needs a late edge
  always_ff @(posedge ser_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      sr_q <= SR_RST;
    else if (ser_enable_in)
      sr_q <= sr_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the system clock

  logic enable_sync;
  logic select_sync;
  logic lock_sync;
  logic mcycle_sync;

  ssw_sync2 u_sync_enable
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(ser_enable_in),
    .sync_out(enable_sync)
  );

  ssw_sync2 u_sync_select
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(buffer_select_input_in),
    .sync_out(select_sync)
  );

  ssw_sync2 u_sync_lock
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(lock_window_in),
    .sync_out(lock_sync)
  );

  ssw_sync2 u_sync_mcycle
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(m_cycle_end_in),
    .sync_out(mcycle_sync)
  );

  logic enable_last_q;
  logic mcycle_last_q;
  logic load_strobe;
  logic mcycle_strobe;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      enable_last_q <= 1'b0;
      mcycle_last_q <= 1'b0;
    end
    else
    begin
      enable_last_q <= enable_sync;
      mcycle_last_q <= mcycle_sync;
    end
  end

  // sr_q is read only here; enable low freezes it, so it is quiet by now
  assign load_strobe = enable_last_q & ~enable_sync;
  assign mcycle_strobe = mcycle_sync & ~mcycle_last_q;

  ////////////////////////////////////////////////////////////////////////////
  // buffer load decode

  logic [1:0] sel_code;
  logic load_one;
  logic load_two;
  logic load_a_hold;
  logic load_ref;

  assign sel_code = {sr_q[SEL_HI_POS], sr_q[SEL_LO_POS]};
  assign load_one = load_strobe & (sel_code == SEL_FREQ_ONE);
  assign load_two = load_strobe & (sel_code == SEL_FREQ_TWO);
  assign load_a_hold = load_strobe & (sel_code == SEL_A_HOLD);
  assign load_ref = load_strobe & (sel_code == SEL_REF);

  logic [FREQ_W-1:0] freq_word_one_buffer_q;
  logic [FREQ_W-1:0] freq_word_two_buffer_q;
  logic [A_W-1:0] a_count_hold_buffer_q;
  logic [REF_W-1:0] reference_word_buffer_q;

  // a buffer changes only on its own load; the others keep control
  // store has no power-down gating, so loads are accepted at any time
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      freq_word_one_buffer_q <= FREQ_RST;
      freq_word_two_buffer_q <= FREQ_RST;
      a_count_hold_buffer_q <= A_HOLD_RST;
      reference_word_buffer_q <= REF_RST;
    end
    else
    begin
      if (load_one)
        freq_word_one_buffer_q <= sr_q[WORD_LSB +: FREQ_W];
      if (load_two)
        freq_word_two_buffer_q <= sr_q[WORD_LSB +: FREQ_W];
      if (load_a_hold)
        a_count_hold_buffer_q <= sr_q[A_HOLD_LSB +: A_W];
      if (load_ref)
        reference_word_buffer_q <= sr_q[WORD_LSB +: REF_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active word, switched and reloaded once per counter cycle

  ssw_act_e active_q;
  ssw_act_e active_d;
  logic [FREQ_W-1:0] active_word_q;
  logic [FREQ_W-1:0] active_word_d;

  // a select change waits for the cycle boundary so counters never see a mix
  assign active_d = select_sync ? SSW_ACT_ONE : SSW_ACT_TWO;
  assign active_word_d = (active_d == SSW_ACT_ONE) ? freq_word_one_buffer_q
                                                   : freq_word_two_buffer_q;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      active_q <= SSW_ACT_ONE;
      active_word_q <= FREQ_RST;
    end
    else if (mcycle_strobe)
    begin
      active_q <= active_d;
      active_word_q <= active_word_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  logic [1:0] gain_code;
  logic sense_bit;
  logic [1:0] pump_enable_code;
  logic [CNT_W-1:0] count_field;

  assign gain_code = {active_word_q[GAIN_HI_POS], active_word_q[GAIN_LO_POS]};
  assign sense_bit = active_word_q[SENSE_POS];
  assign count_field = active_word_q[CNT_W-1:0];
  assign pump_enable_code = {reference_word_buffer_q[PE_HI_POS],
                             reference_word_buffer_q[PE_LO_POS]};

  ////////////////////////////////////////////////////////////////////////////
  // next values of the pump controls

  logic [7:0] cp1_ua_d;
  logic [3:0] cp2_half_d;
  logic cp1_on_d;
  logic refs_on_d;

  assign cp1_ua_d = cp1_ua(gain_code);
  assign cp2_half_d = cp2_half(gain_code);
  // lock comes through the synchroniser, so gating lags the window a little
  assign cp1_on_d = pump1_on(pump_enable_code, lock_sync);
  assign refs_on_d = refs_on(pump_enable_code);

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      m_ratio_out <= '0;
      a_ratio_out <= '0;
      a_count_hold_out <= A_HOLD_RST;
      ref_ratio_out <= '0;
      prescaler_low_pair_out <= 1'b0;
      cp1_current_ua_out <= CP1_UA_00;
      cp2_scale_half_out <= CP2_HALF_00;
      pump_sink_out <= 1'b0;
      port_swap_out <= 1'b0;
      cp1_enable_out <= 1'b1;
      cp2_enable_out <= 1'b1;
      ref_outputs_enable_out <= 1'b0;
      lock_detect_n_out <= 1'b1;
      active_is_one_out <= 1'b1;
    end
    else
    begin
      m_ratio_out <= count_field[M_LSB +: M_W];
      a_ratio_out <= count_field[A_LSB +: A_W];
      a_count_hold_out <= a_count_hold_buffer_q;
      // a zero ratio is passed through; the divider treats 1..8191 as valid
      ref_ratio_out <= reference_word_buffer_q[RATIO_W-1:0];
      prescaler_low_pair_out <= reference_word_buffer_q[MOD_POS];
      cp1_current_ua_out <= cp1_ua_d;
      cp2_scale_half_out <= cp2_half_d;
      pump_sink_out <= sense_bit;
      port_swap_out <= sense_bit;
      cp1_enable_out <= cp1_on_d;
      cp2_enable_out <= 1'b1;
      ref_outputs_enable_out <= refs_on_d;
      lock_detect_n_out <= ~lock_sync;
      active_is_one_out <= (active_q == SSW_ACT_ONE);
    end
  end
endmodule

/* File: tb/ssw_host_model.sv */
// behavioural host programming the store over the three-wire link
`timescale 1ns/100ps
module ssw_host_model
(
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_enable_out
);
  initial
  begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b1;
    ser_enable_out = 1'b0;
  end
  // link clock of 6 ns runs only inside a frame
  task automatic send(input logic [25:0] frame, input int n);
    #1.7 ser_enable_out = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_data_out = frame[i];
      #3 ser_clk_out = 1'b1;
      #3 ser_clk_out = 1'b0;
    end
    #3 ser_enable_out = 1'b0;
    ser_data_out = ~ser_data_out;
    // gap keeps the next frame clear of the commit
    #250;
  endtask
endmodule

/* File: tb/ssw_word_store_properties.sv */
// assertion checker for the serial word store
`timescale 1ns/100ps
module ssw_word_store_properties
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ser_enable_in,
  input wire logic buffer_select_input_in,
  input wire logic lock_window_in,
  input wire logic m_cycle_end_in,
  input wire logic [3:0] a_count_hold_out,
  input wire logic [12:0] ref_ratio_out,
  input wire logic [7:0] cp1_current_ua_out,
  input wire logic [3:0] cp2_scale_half_out,
  input wire logic pump_sink_out,
  input wire logic port_swap_out,
  input wire logic cp1_enable_out,
  input wire logic cp2_enable_out,
  input wire logic ref_outputs_enable_out,
  input wire logic lock_detect_n_out,
  input wire logic active_is_one_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////
  AST_CP2_ON: assert property (cp2_enable_out)
    else $error("pump two off");
  AST_GAIN_PAIR: assert property ({cp1_current_ua_out, cp2_scale_half_out}
    inside {12'h322, 12'h4B3, 12'h7D5, 12'hC88}) else $error("gain pair");
  AST_SENSE: assert property (pump_sink_out == port_swap_out)
    else $error("sense split");
  AST_LOCK_LOW: assert property (lock_window_in [*5] |-> !lock_detect_n_out)
    else $error("lock not shown");
  AST_LOCK_HIGH: assert property (!lock_window_in [*5] |-> lock_detect_n_out)
    else $error("false lock");
  AST_GATED: assert property (!cp1_enable_out && !ref_outputs_enable_out |->
    !lock_detect_n_out) else $error("pump one off unlocked");
  // a new frame starts well after the last commit, so stores must be quiet
  AST_STORE_HOLD: assert property (ser_enable_in [*3] |->
    $stable({ref_ratio_out, a_count_hold_out})) else $error("store moved");
  AST_ACTIVE_QUIET: assert property (!m_cycle_end_in [*8] |->
    $stable({active_is_one_out, cp1_current_ua_out, pump_sink_out})) else $error("word moved");
  AST_SEL_ONE: assert property (buffer_select_input_in [*4] ##0 $rose(m_cycle_end_in)
    |-> ##[2:7] active_is_one_out) else $error("word one not active");
  AST_SEL_TWO: assert property (!buffer_select_input_in [*4] ##0 $rose(m_cycle_end_in)
    |-> ##[2:7] !active_is_one_out) else $error("word two not active");
endmodule
bind ssw_word_store ssw_word_store_properties u_props
(
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .ser_enable_in(ser_enable_in),
  .buffer_select_input_in(buffer_select_input_in),
  .lock_window_in(lock_window_in),
  .m_cycle_end_in(m_cycle_end_in),
  .a_count_hold_out(a_count_hold_out),
  .ref_ratio_out(ref_ratio_out),
  .cp1_current_ua_out(cp1_current_ua_out),
  .cp2_scale_half_out(cp2_scale_half_out),
  .pump_sink_out(pump_sink_out),
  .port_swap_out(port_swap_out),
  .cp1_enable_out(cp1_enable_out),
  .cp2_enable_out(cp2_enable_out),
  .ref_outputs_enable_out(ref_outputs_enable_out),
  .lock_detect_n_out(lock_detect_n_out),
  .active_is_one_out(active_is_one_out)
);

/* File: tb/testbench.sv */
// self-checking bench for the serial word store
`timescale 1ns/100ps
module testbench;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic bsel = 1'b1;
  logic lock = 1'b0;
  logic mend = 1'b0;
  wire sclk, sdat, sen;
  logic [14:0] m_o;
  logic [3:0] a_o, h_o, c2_o;
  logic [12:0] r_o;
  logic [7:0] c1_o;
  logic lp_o, snk_o, swp_o, e1_o, e2_o, re_o, ld_o, act_o;
  int errors = 0;
  int comparisons = 0;
  logic [21:0] w1 = '0, w2 = '0, aw = '0;
  logic [15:0] rw = '0;
  logic [3:0] hold = '0;
  logic act = 1'b1;
  logic [31:0] lfsr = 32'h5895;
  logic [63:0] q[$];
  event ev;
  wire [63:0] obs = {8'h0, c1_o, c2_o, snk_o, swp_o, e1_o, e2_o, re_o, ld_o, act_o,
    m_o, a_o, h_o, r_o, lp_o};
  always #20 clk_in = ~clk_in;
  ssw_word_store DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .ser_clk_in(sclk),
    .ser_data_in(sdat), .ser_enable_in(sen), .buffer_select_input_in(bsel),
    .lock_window_in(lock), .m_cycle_end_in(mend), .m_ratio_out(m_o), .a_ratio_out(a_o),
    .a_count_hold_out(h_o), .ref_ratio_out(r_o), .prescaler_low_pair_out(lp_o),
    .cp1_current_ua_out(c1_o), .cp2_scale_half_out(c2_o), .pump_sink_out(snk_o),
    .port_swap_out(swp_o), .cp1_enable_out(e1_o), .cp2_enable_out(e2_o),
    .ref_outputs_enable_out(re_o), .lock_detect_n_out(ld_o), .active_is_one_out(act_o));
  ssw_host_model HOST (.ser_clk_out(sclk), .ser_data_out(sdat), .ser_enable_out(sen));
  ////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] expect_now();
    logic [7:0] ua [4] = '{8'h32, 8'h7D, 8'h4B, 8'hC8};
    logic [3:0] hs [4] = '{4'h2, 4'h5, 4'h3, 4'h8};
    logic [1:0] g;
    logic [1:0] pe;
    logic e1;
    g = aw[20:19];
    pe = rw[14:13];
    e1 = (pe == 2'h0) | ((pe != 2'h2) & ~lock);
    expect_now = {8'h0, ua[g], hs[g], aw[21], aw[21], e1, 1'b1, pe[1], ~lock, act,
      aw[18:4], aw[3:0], hold, rw[12:0], rw[15]};
  endfunction
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic check();
    cycles(8);
    q.push_back(expect_now());
    // compare away from the launching edge so outputs have settled
    @(negedge clk_in);
    -> ev;
  endtask
  task automatic load(input logic [21:0] w, input logic [1:0] sel);
    if (sel != 2'h3 && rw[15]) w[3] = 1'b0;
    HOST.send({2'b0, w, sel}, sel == 2'h3 ? 18 : 24);
    case (sel)
      2'h0: w1 = w;
      2'h2: w2 = w;
      2'h1: hold = w[3:0];
      default: rw = w[15:0];
    endcase
  endtask
  task automatic strobe(input logic s);
    @(posedge clk_in);
    bsel <= s;
    cycles(4);
    mend <= 1'b1;
    cycles(3);
    mend <= 1'b0;
    act = s;
    aw = s ? w1 : w2;
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(ev)
  begin
    logic [63:0] e;
    e = q.pop_front();
    comparisons++;
    if (obs !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, obs, e);
    end
  end
  // whole run needs about 23 us; over eight times that means a hang
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
  initial
  begin
    logic [21:0] w;
    cycles(5);
    reset_n_in <= 1'b1;
    check();
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      load({6'h0, i[2], i[1:0], i[2] ? 13'h1FFF : 13'h0001}, 2'h3);
      for (int k = 0; k < 2; k++)
      begin
        @(posedge clk_in);
        lock <= k[0];
        check();
      end
    end
    $display("test reference done");
    for (int i = 0; i < 8; i++)
    begin
      lfsr = next_rand(lfsr);
      w = {lfsr[21], i[1:0], lfsr[18:0]};
      load(w, i[0] ? 2'h2 : 2'h0);
      lfsr = next_rand(lfsr);
      load(lfsr[21:0], 2'h1);
      strobe(~i[0]);
      check();
    end
    $display("test frequency done");
    lfsr = next_rand(lfsr);
    load(lfsr[21:0], 2'h0);
    check();
    strobe(1'b0);
    check();
    strobe(1'b1);
    check();
    $display("test inactive done");
    complete_run();
  end
endmodule
